// file: fwb_pkg.sv
// Purpose: Shared constants for the frame tag and white balance stage
// Assumes: 250 MHz system clock, byte addressed register port
// Notes: Offsets are byte addresses, one 32-bit word per register
`default_nettype none
package fwb_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] A_CTRL = 16'h0000;
  localparam logic [15:0] A_WB = 16'h0004;
  localparam logic [15:0] A_GAIN = 16'h0008;
  localparam logic [15:0] A_BRIGHT = 16'h000c;
  localparam logic [15:0] A_GAMMA = 16'h0010;
  localparam logic [15:0] A_HRATE = 16'h0014;
  localparam logic [15:0] A_SERIAL = 16'h0018;
  localparam logic [15:0] A_BGAIN = 16'h001c;
  localparam logic [15:0] A_STATUS = 16'h0020;
  localparam logic [15:0] A_SENS = 16'h0040;
  localparam logic [15:0] A_MAP = 16'h1040;
  localparam logic [15:0] A_TIME = 16'h1ea8;
  // ****************************************
  // Timing and timestamp fields
  // ****************************************
  localparam int CLK_HZ = 250_000_000;
  localparam int TICK_HZ = 8000;
  localparam int TICK_DIV = CLK_HZ / TICK_HZ;
  localparam logic [12:0] TICK_MAX = 13'h1f3f;
  localparam logic [6:0] SEC_MAX = 7'h7f;
  localparam logic [3:0] FRAC_PAD = 4'h0;
  // ****************************************
  // Gains and balance loop
  // ****************************************
  localparam logic [7:0] GAIN_UNITY = 8'h40;
  localparam int REL_SHIFT = 9;
  localparam int PIX_SHIFT = 6;
  localparam logic [9:0] WB_DEF_COLOR = 10'h3ff;
  localparam logic [9:0] WB_DEF_MONO = 10'h020;
  localparam logic [9:0] WB_MAX = 10'h3ff;
  localparam logic [7:0] WHITE_THR = 8'hf0;
  localparam logic [7:0] THR_STEP = 8'h08;
  localparam logic [7:0] AUTO_MARGIN = 8'h10;
  localparam logic [4:0] OS_ITERS = 5'h10;
  // ****************************************
  // Colour pattern and header layout
  // ****************************************
  localparam logic [1:0] C_RED = 2'h0;
  localparam logic [1:0] C_GRN = 2'h1;
  localparam logic [1:0] C_BLU = 2'h2;
  localparam logic [7:0] PATTERN_RGGB = 8'h94;
  localparam int NUM_SENS = 6;
  localparam int HDR_WORDS = 16;
  localparam logic [5:0] HDR_LAST = 6'h3f;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = 9;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_HDR = 2'b01,
    ST_PAY = 2'b10
  } frame_st_e;
  typedef enum logic [1:0] {
    WB_OFF = 2'b00,
    WB_MAN = 2'b01,
    WB_AUTO = 2'b10,
    WB_ONCE = 2'b11
  } wb_mode_e;
endpackage
`default_nettype wire

// file: byte_fifo.sv
// Purpose: Show-ahead FIFO with registered output stage
// Assumes: Single clock, synchronous active high reset
// Notes: in_ready drops four words early to cover one pipeline stage
`default_nettype none
module byte_fifo #(
  parameter int W = 9,
  parameter int D = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;
  // Honest full and empty guards
  assign push = in_valid && (cnt_q != (AW+1)'(D));
  assign pop = (cnt_q != '0) && (!out_valid || out_ready);
  assign in_ready = cnt_q < (AW+1)'(D - 4);
  // Storage
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  // Pointers and fill count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
  // Output register
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data <= mem_q[rd_q];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: frame_tag_wb.sv
// Purpose: Frame header tagging and Bayer white balance gain stage
// Assumes: Pixel source and exposure logic share clk_sys
// Notes: Header of 64 bytes, least byte first, precedes each payload
//
// Local design decision: the plain strobed port.
`default_nettype none
module frame_tag_wb #(
  parameter int TICK_DIV = fwb_pkg::TICK_DIV,
  parameter bit COLOR = 1'b1,
  parameter logic [31:0] SERIAL_NUM = 32'h00001234
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic integ_end,
  input wire logic pix_valid,
  input wire logic [7:0] pix_data,
  input wire logic pix_eol,
  input wire logic pix_eof,
  output logic pix_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  output logic out_hdr,
  input wire logic out_ready
);
  // SERIAL_NUM default is arbitrary
  fwb_pkg::wb_mode_e mode_q;
  fwb_pkg::frame_st_e st_q;
  logic [7:0] gain_q, bright_q, gamma_q, bgain_q;
  logic [15:0] hrate_q;
  logic [9:0] red_q, blue_q;
  logic [31:0] sens_w [fwb_pkg::NUM_SENS];
  logic [31:0] hdr_q [fwb_pkg::HDR_WORDS];
  logic [14:0] div_q;
  logic [12:0] tick_q;
  logic [6:0] sec_q;
  logic [31:0] ts_w, seq_q, rd_w, word_w;
  logic tick_en, hdr_pend_q, take, f_rdy, f_in_v, row_q, col_q;
  logic [5:0] hidx_q;
  logic [8:0] f_in_d, f_out_d;
  logic [7:0] map_w, val_w, thr_q, pmax_q;
  logic [1:0] code_in, s1_code_q;
  logic [9:0] rel_w;
  logic [17:0] prod_w;
  logic [8:0] eff_w, s1_eff_q;
  logic s1_v_q, s1_eof_q, os_busy_q, frm_end, wb_step;
  logic [7:0] s1_pix_q;
  logic [16:0] mul_w;
  logic [10:0] scl_w;
  logic [23:0] sum_r_q, sum_g_q, sum_b_q;
  logic [15:0] cnt_w_q;
  logic [4:0] os_iter_q;

  // ****************************************
  // Register port
  // ****************************************
  // Control registers written by software
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= fwb_pkg::WB_OFF;
      gain_q <= fwb_pkg::GAIN_UNITY;
      bright_q <= '0;
      gamma_q <= '0;
      bgain_q <= '0;
      hrate_q <= '0;
    end else if (reg_wr) begin
      case (reg_addr)
        fwb_pkg::A_CTRL: mode_q <= fwb_pkg::wb_mode_e'(reg_wdata[1:0]);
        fwb_pkg::A_GAIN: gain_q <= reg_wdata[7:0];
        fwb_pkg::A_BRIGHT: bright_q <= reg_wdata[7:0];
        fwb_pkg::A_GAMMA: gamma_q <= reg_wdata[7:0];
        fwb_pkg::A_BGAIN: bgain_q <= reg_wdata[7:0];
        fwb_pkg::A_HRATE: hrate_q <= reg_wdata[15:0];
        default: ;
      endcase
    end
  end

  // Per-sensor gain and shutter words
  for (genvar gi = 0; gi < fwb_pkg::NUM_SENS; gi++) begin : g_sens
    logic [31:0] q;
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        q <= '0;
      end else if (reg_wr && reg_addr == fwb_pkg::A_SENS + 16'(gi * 4)) begin
        q <= reg_wdata;
      end
    end
    assign sens_w[gi] = q;
  end

  // Read mux, zero for unmapped offsets
  always_comb begin
    rd_w = '0;
    case (reg_addr)
      fwb_pkg::A_CTRL: rd_w = {30'h0, mode_q};
      fwb_pkg::A_WB: rd_w = {6'h0, blue_q, 6'h0, red_q};
      fwb_pkg::A_GAIN: rd_w = {24'h0, gain_q};
      fwb_pkg::A_BRIGHT: rd_w = {24'h0, bright_q};
      fwb_pkg::A_GAMMA: rd_w = {24'h0, gamma_q};
      fwb_pkg::A_BGAIN: rd_w = {24'h0, bgain_q};
      fwb_pkg::A_HRATE: rd_w = {16'h0, hrate_q};
      fwb_pkg::A_SERIAL: rd_w = SERIAL_NUM;
      fwb_pkg::A_STATUS: rd_w = {seq_q[15:0], 8'h00, st_q, os_busy_q, os_iter_q};
      fwb_pkg::A_MAP: rd_w = {24'h0, map_w};
      fwb_pkg::A_TIME: rd_w = ts_w;
      default: rd_w = '0;
    endcase
    for (int i = 0; i < fwb_pkg::NUM_SENS; i++) begin
      if (reg_addr == fwb_pkg::A_SENS + 16'(i * 4)) begin
        rd_w = sens_w[i];
      end
    end
  end

  // Read data stands one cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_w : '0;
    end
  end

  // ****************************************
  // Timestamp
  // ****************************************
  assign tick_en = div_q == 15'(TICK_DIV - 1);
  // Low four bits padded, not a true offset
  assign ts_w = {sec_q, tick_q, div_q[14:7], fwb_pkg::FRAC_PAD};

  // Tick prescaler and counters
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      div_q <= '0;
      tick_q <= '0;
      sec_q <= '0;
    end else begin
      div_q <= tick_en ? '0 : div_q + 1'b1;
      if (tick_en) begin
        if (tick_q == fwb_pkg::TICK_MAX) begin
          tick_q <= '0;
          sec_q <= (sec_q == fwb_pkg::SEC_MAX) ? '0 : sec_q + 1'b1;
        end else begin
          tick_q <= tick_q + 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Header capture and sequencing
  // ****************************************
  // Snapshot at end of integration
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      seq_q <= '0;
      for (int i = 0; i < fwb_pkg::HDR_WORDS; i++) begin
        hdr_q[i] <= '0;
      end
    end else if (integ_end) begin
      hdr_q[0] <= ts_w;
      hdr_q[1] <= seq_q;
      seq_q <= seq_q + 1'b1;
      hdr_q[2] <= {16'h0, hrate_q};
      for (int i = 0; i < fwb_pkg::NUM_SENS; i++) begin
        hdr_q[3 + i] <= sens_w[i];
      end
      hdr_q[9] <= {24'h0, bright_q};
      hdr_q[10] <= {6'h0, blue_q, 6'h0, red_q};
      hdr_q[11] <= {24'h0, gamma_q};
      hdr_q[12] <= {24'h0, bgain_q};
      hdr_q[13] <= {24'h0, map_w};
      hdr_q[14] <= SERIAL_NUM;
      hdr_q[15] <= {30'h0, mode_q};
    end
  end

  assign take = pix_valid && pix_ready;
  assign word_w = hdr_q[hidx_q[5:2]];
  assign f_in_v = (st_q == fwb_pkg::ST_HDR && f_rdy) || s1_v_q;
  assign f_in_d = (st_q == fwb_pkg::ST_HDR) ? {1'b1, 8'(word_w >> {hidx_q[1:0], 3'b000})}
                                           : {1'b0, val_w};

  // Frame state: header first, then payload
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_q <= fwb_pkg::ST_IDLE;
      hidx_q <= '0;
      hdr_pend_q <= 1'b0;
    end else begin
      if (integ_end) begin
        hdr_pend_q <= 1'b1;
      end
      case (st_q)
        fwb_pkg::ST_IDLE: begin
          if (hdr_pend_q && !s1_v_q) begin
            st_q <= fwb_pkg::ST_HDR;
            hidx_q <= '0;
            if (!integ_end) begin
              hdr_pend_q <= 1'b0;
            end
          end
        end
        fwb_pkg::ST_HDR: begin
          if (f_rdy) begin
            hidx_q <= hidx_q + 1'b1;
            if (hidx_q == fwb_pkg::HDR_LAST) begin
              st_q <= fwb_pkg::ST_PAY;
            end
          end
        end
        fwb_pkg::ST_PAY: begin
          if (take && pix_eof) begin
            st_q <= fwb_pkg::ST_IDLE;
          end
        end
        default: st_q <= fwb_pkg::ST_IDLE;
      endcase
    end
  end

  // Pixel ready only during payload with room
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pix_ready <= 1'b0;
    end else begin
      pix_ready <= st_q == fwb_pkg::ST_PAY && f_rdy && !(take && pix_eof);
    end
  end

  // ****************************************
  // Bayer gain stage
  // ****************************************
  assign map_w = fwb_pkg::PATTERN_RGGB;
  assign code_in = 2'(map_w >> {row_q, col_q, 1'b0});
  assign rel_w = (code_in == fwb_pkg::C_RED) ? red_q : blue_q;
  assign prod_w = gain_q * rel_w;
  // Half scale relative code leaves common gain unchanged
  assign eff_w = (mode_q == fwb_pkg::WB_OFF || code_in == fwb_pkg::C_GRN)
                 ? {1'b0, gain_q}
                 : 9'(prod_w >> fwb_pkg::REL_SHIFT);
  assign mul_w = s1_pix_q * s1_eff_q;
  assign scl_w = 11'(mul_w >> fwb_pkg::PIX_SHIFT);
  assign val_w = (scl_w > 11'h0ff) ? 8'hff : scl_w[7:0];

  // Row and column parity in raster order
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      row_q <= 1'b0;
      col_q <= 1'b0;
    end else if (take) begin
      col_q <= (pix_eol || pix_eof) ? 1'b0 : !col_q;
      if (pix_eof) begin
        row_q <= 1'b0;
      end else if (pix_eol) begin
        row_q <= !row_q;
      end
    end
  end

  // Single pipeline stage into the FIFO
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s1_v_q <= 1'b0;
      s1_pix_q <= '0;
      s1_eff_q <= '0;
      s1_code_q <= '0;
      s1_eof_q <= 1'b0;
    end else begin
      s1_v_q <= take;
      s1_pix_q <= pix_data;
      s1_eff_q <= eff_w;
      s1_code_q <= code_in;
      s1_eof_q <= take && pix_eof;
    end
  end

  byte_fifo #(
    .W(fwb_pkg::FIFO_W),
    .D(fwb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_valid(f_in_v),
    .in_data(f_in_d),
    .in_ready(f_rdy),
    .out_valid(out_valid),
    .out_data(f_out_d),
    .out_ready(out_ready)
  );
  assign out_data = f_out_d[7:0];
  assign out_hdr = f_out_d[8];

  // ****************************************
  // Balance loop
  // ****************************************
  assign frm_end = s1_v_q && s1_eof_q;
  assign wb_step = frm_end && cnt_w_q != '0 &&
                   (mode_q == fwb_pkg::WB_AUTO || (mode_q == fwb_pkg::WB_ONCE && os_busy_q));

  // Frame statistics over all pixels but the last of the frame: maximum, sums and count of pixels at or above threshold
  always_ff @(posedge clk_sys) begin
    if (reset || frm_end) begin
      sum_r_q <= '0;
      sum_g_q <= '0;
      sum_b_q <= '0;
      cnt_w_q <= '0;
      pmax_q <= '0;
    end else if (s1_v_q) begin
      if (val_w > pmax_q) begin
        pmax_q <= val_w;
      end
      if (val_w >= thr_q) begin
        cnt_w_q <= cnt_w_q + 1'b1;
        case (s1_code_q)
          fwb_pkg::C_RED: sum_r_q <= sum_r_q + 24'(val_w);
          fwb_pkg::C_BLU: sum_b_q <= sum_b_q + 24'(val_w);
          default: sum_g_q <= sum_g_q + 24'(val_w);
        endcase
      end
    end
  end

  // Threshold: white first, then lowered toward brightest
  always_ff @(posedge clk_sys) begin
    if (reset || (reg_wr && reg_addr == fwb_pkg::A_CTRL)) begin
      thr_q <= fwb_pkg::WHITE_THR;
    end else if (frm_end) begin
      if (mode_q == fwb_pkg::WB_AUTO) begin
        thr_q <= (pmax_q > fwb_pkg::AUTO_MARGIN) ? pmax_q - fwb_pkg::AUTO_MARGIN : '0;
      end else if (cnt_w_q == '0 && thr_q > fwb_pkg::THR_STEP) begin
        thr_q <= thr_q - fwb_pkg::THR_STEP;
      end
    end
  end

  // Single-shot iteration budget
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      os_busy_q <= 1'b0;
      os_iter_q <= '0;
    end else if (reg_wr && reg_addr == fwb_pkg::A_CTRL) begin
      os_busy_q <= reg_wdata[1:0] == fwb_pkg::WB_ONCE;
      os_iter_q <= '0;
    end else if (frm_end && os_busy_q) begin
      os_iter_q <= os_iter_q + 1'b1;
      if (os_iter_q == fwb_pkg::OS_ITERS - 5'h01) begin
        os_busy_q <= 1'b0;
      end
    end
  end

  // Red and blue settings, software write wins
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      red_q <= COLOR ? fwb_pkg::WB_DEF_COLOR : fwb_pkg::WB_DEF_MONO;
      blue_q <= COLOR ? fwb_pkg::WB_DEF_COLOR : fwb_pkg::WB_DEF_MONO;
    end else if (reg_wr && reg_addr == fwb_pkg::A_WB) begin
      red_q <= reg_wdata[9:0];
      blue_q <= reg_wdata[25:16];
    end else if (wb_step) begin
      if ({sum_r_q, 1'b0} < {1'b0, sum_g_q} && red_q != fwb_pkg::WB_MAX) begin
        red_q <= red_q + 1'b1;
      end else if ({sum_r_q, 1'b0} > {1'b0, sum_g_q} && red_q != '0) begin
        red_q <= red_q - 1'b1;
      end
      if ({sum_b_q, 1'b0} < {1'b0, sum_g_q} && blue_q != fwb_pkg::WB_MAX) begin
        blue_q <= blue_q + 1'b1;
      end else if ({sum_b_q, 1'b0} > {1'b0, sum_g_q} && blue_q != '0) begin
        blue_q <= blue_q - 1'b1;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_hdr_start;
    st_q == fwb_pkg::ST_IDLE && hdr_pend_q && !s1_v_q;
  endsequence
  sequence s_hdr_run;
    st_q == fwb_pkg::ST_HDR [*1];
  endsequence
  chk_tick_wrap: assert property (tick_en && tick_q == fwb_pkg::TICK_MAX |=> tick_q == '0)
    else $error("tick counter did not wrap");
  chk_sec_step: assert property (tick_en && tick_q == fwb_pkg::TICK_MAX
    |=> sec_q == 7'($past(sec_q) + 1'b1))
    else $error("seconds did not advance");
  chk_sec_hold: assert property (!(tick_en && tick_q == fwb_pkg::TICK_MAX) |=> $stable(sec_q))
    else $error("seconds moved off wrap");
  chk_hdr_first: assert property (s_hdr_start |=> s_hdr_run ##0 !pix_ready)
    else $error("header not started before payload");
  chk_hdr_snap: assert property (integ_end |=> hdr_q[0] == $past(ts_w)
    && seq_q == $past(seq_q) + 1'b1)
    else $error("header snapshot wrong");
  chk_time_read: assert property (reg_rd && reg_addr == fwb_pkg::A_TIME
    |=> reg_rdata == $past(ts_w))
    else $error("time register mismatch");
  chk_map_read: assert property (reg_rd && reg_addr == fwb_pkg::A_MAP
    |=> reg_rdata == {24'h0, fwb_pkg::PATTERN_RGGB})
    else $error("pattern register mismatch");
  chk_off_gain: assert property (take && mode_q == fwb_pkg::WB_OFF
    |=> s1_eff_q == {1'b0, $past(gain_q)})
    else $error("common gain not applied");
  chk_red_gain: assert property (take && mode_q != fwb_pkg::WB_OFF && code_in == fwb_pkg::C_RED
    |=> s1_eff_q == 9'((18'($past(gain_q)) * $past(red_q)) >> fwb_pkg::REL_SHIFT))
    else $error("red gain not applied");
  chk_os_stop: assert property (frm_end && os_busy_q && os_iter_q == fwb_pkg::OS_ITERS - 5'h01
    && !reg_wr |=> !os_busy_q ##1 !wb_step || mode_q != fwb_pkg::WB_ONCE)
    else $error("single shot did not stop");
  chk_raw_order: assert property (take && pix_eol && !pix_eof |=> !col_q
    && row_q != $past(row_q))
    else $error("raster order broken");
endmodule
`default_nettype wire

// file: frame_sink.sv
// Purpose: Host side sink for the framed byte stream
// Assumes: Shares clk_sys with the stage, random back-pressure
// Notes: Each accepted byte is handed to the bench one cycle later
`default_nettype none
module frame_sink (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic hold,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_hdr,
  output logic out_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_hdr
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] hdr_cnt_q;
  // ****
  // Random stalls and capture of bytes
  // ****
  always_ff @(posedge clk_sys) begin
    out_ready <= !reset && !hold && ($urandom % 4 != 0);
    rx_valid <= !reset && out_valid && out_ready;
    rx_hdr <= out_hdr;
    rx_data <= out_data;
    // Low nibble of the timestamp carries no meaning
    if (out_valid && out_ready && out_hdr && hdr_cnt_q == 6'h00) begin
      rx_data <= out_data & 8'hf0;
    end
    if (reset) begin
      hdr_cnt_q <= 6'h00;
    end else if (out_valid && out_ready && out_hdr) begin
      hdr_cnt_q <= hdr_cnt_q + 6'h01;
    end
  end
endmodule
`default_nettype wire

// file: frame_tag_wb_test.sv
// Purpose: Self-checking bench of the frame tag and balance stage
// Assumes: Tick divider shortened to 4 cycles
// Notes: Random pixels, fixed seed, header fields checked where known
`default_nettype none
module frame_tag_wb_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, integ_end = 1'b0;
  logic pix_valid = 1'b0, pix_eol = 1'b0, pix_eof = 1'b0, hold = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rd_q, t0, s0;
  logic [7:0] pix_data = 8'h00, out_data, rx_data;
  logic pix_ready, out_valid, out_hdr, out_ready, rx_valid, rx_hdr;
  logic [9:0] expq[$];
  logic [9:0] e;
  int errors = 0, cmp_count = 0, cyc = 0, sr = 0, sg = 0, sb = 0, nf = 0;
  frame_tag_wb #(.TICK_DIV(4), .COLOR(1'b1), .SERIAL_NUM(32'h00005a5a)) frame_tag_wb_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .integ_end(integ_end),
    .pix_valid(pix_valid), .pix_data(pix_data), .pix_eol(pix_eol), .pix_eof(pix_eof),
    .pix_ready(pix_ready), .out_valid(out_valid), .out_data(out_data), .out_hdr(out_hdr),
    .out_ready(out_ready));
  frame_sink frame_sink_inst (.clk_sys(clk_sys), .reset(reset), .hold(hold),
    .out_valid(out_valid), .out_data(out_data), .out_hdr(out_hdr), .out_ready(out_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_hdr(rx_hdr));
  // ****
  // Clock, helpers and bus tasks
  // ****
  initial begin
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
  // Output byte expected for a pixel at a given place
  function automatic logic [7:0] exp_px(input logic [7:0] p, input logic [1:0] m,
      input logic [31:0] wb, input int r, input int c);
    logic [17:0] eff;
    logic [17:0] v;
    eff = 18'h40;
    if (m != 2'h0 && r % 2 == 0 && c % 2 == 0) eff = (18'h40 * wb[9:0]) >> 9;
    if (m != 2'h0 && r % 2 == 1 && c % 2 == 1) eff = (18'h40 * wb[25:16]) >> 9;
    v = (p * eff) >> 6;
    return (v > 18'hff) ? 8'hff : v[7:0];
  endfunction
  // One balance step toward twice the colour sum matching green
  function automatic logic [9:0] step(input logic [9:0] v, input int s, input int g);
    if (2 * s < g) return v + 10'h001;
    if (2 * s > g) return v - 10'h001;
    return v;
  endfunction
  task automatic px(input logic [7:0] d, input logic l, input logic f);
    int n;
    n = 0;
    pix_valid <= 1'b1;
    pix_data <= d;
    pix_eol <= l;
    pix_eof <= f;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pix_ready !== 1'b1 && n < 2000);
    check(32'(pix_ready), 32'h1);
  endtask
  // One frame: header capture, stalled sink, 3 rows of 4 pixels
  task automatic frame(input logic [1:0] m, input logic [31:0] wb);
    logic [7:0] p;
    logic [31:0] v;
    logic c;
    int n;
    logic [7:0] x;
    sr = 0;
    sg = 0;
    sb = 0;
    // Single-shot is armed once by the caller so its budget can run out
    if (m != 2'h3) wr(fwb_pkg::A_CTRL, {30'h0, m});
    wr(fwb_pkg::A_WB, wb);
    wr(fwb_pkg::A_BRIGHT, 32'h0000005a);
    hold <= 1'b1;
    integ_end <= 1'b1;
    @(posedge clk_sys);
    integ_end <= 1'b0;
    wr(fwb_pkg::A_BRIGHT, 32'h000000a5);
    for (int k = 0; k < 64; k++) begin
      c = 1'b1;
      case (k / 4)
        1: v = 32'(s0[31:16]) + 32'(nf);
        2: v = 32'h00000321;
        3, 4, 5, 6, 7, 8, 11, 12: v = 32'h0;
        9: v = 32'h0000005a;
        10: v = wb;
        13: v = 32'h00000094;
        14: v = 32'h00005a5a;
        15: v = 32'(m);
        default: c = 1'b0;
      endcase
      expq.push_back({c, 1'b1, v[8*(k%4)+:8]});
    end
    repeat (30) @(posedge clk_sys);
    hold <= 1'b0;
    for (int r = 0; r < 3; r++) begin
      for (int q = 0; q < 4; q++) begin
        p = (r < 2 && q < 2) ? 8'hff : (r == 2 && q == 3) ? 8'h00 : 8'($urandom);
        x = exp_px(p, m, wb, r, q);
        expq.push_back({2'b10, x});
        // Bright pixel sums per colour for the balance step
        if (x >= fwb_pkg::WHITE_THR && r % 2 == 0 && q % 2 == 0) sr += int'(x);
        if (x >= fwb_pkg::WHITE_THR && r % 2 == 1 && q % 2 == 1) sb += int'(x);
        if (x >= fwb_pkg::WHITE_THR && r % 2 != q % 2) sg += int'(x);
        px(p, q == 3, r == 2 && q == 3);
      end
    end
    pix_valid <= 1'b0;
    n = 0;
    while (expq.size() != 0 && n < 3000) begin
      @(posedge clk_sys);
      n++;
    end
    check(32'(expq.size()), 32'h0);
    expq.delete();
    nf++;
  endtask
  // ****
  // Stream monitor and watchdog
  // ****
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      report_and_stop();
    end
    if (rx_valid === 1'b1) begin
      if (expq.size() == 0) begin
        errors++;
        $display("wrong value at %0t: got %h expected %h", $time, rx_data, 8'h00);
      end else begin
        e = expq.pop_front();
        if (e[9]) check(32'({rx_hdr, rx_data}), 32'(e[8:0]));
        else check(32'(rx_hdr), 32'(e[8]));
      end
    end
  end
  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(51));
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    rd(fwb_pkg::A_WB, rd_q);
    check(rd_q, 32'h03ff03ff);
    wr(fwb_pkg::A_MAP, 32'h0);
    rd(fwb_pkg::A_MAP, rd_q);
    check(rd_q, 32'h00000094);
    rd(16'h0ffc, rd_q);
    check(rd_q, 32'h0);
    for (int m = 3; m >= 0; m--) begin
      wr(fwb_pkg::A_CTRL, 32'(m));
      rd(fwb_pkg::A_CTRL, rd_q);
      check(32'(rd_q[1:0]), 32'(m));
    end
    rd(fwb_pkg::A_TIME, t0);
    repeat (31998) @(posedge clk_sys);
    rd(fwb_pkg::A_TIME, rd_q);
    check(32'(rd_q[31:4]), 32'(t0[31:4] + 28'h0200000));
    wr(fwb_pkg::A_HRATE, 32'h00000321);
    rd(fwb_pkg::A_STATUS, s0);
    frame(2'h0, 32'h03ff03ff);
    frame(2'h1, 32'h03ff0200);
    rd(fwb_pkg::A_STATUS, rd_q);
    check(32'(rd_q[31:16]), 32'(s0[31:16] + 16'h0002));
    // Automatic balance moves red and blue one step after a frame
    frame(2'h2, 32'h02000200);
    rd(fwb_pkg::A_WB, rd_q);
    check(rd_q, {6'h0, step(10'h200, sb, sg), 6'h0, step(10'h200, sr, sg)});
    // Single shot armed once, must stop after its frame budget
    wr(fwb_pkg::A_CTRL, 32'h3);
    for (int f = 0; f < 16; f++) begin
      rd(fwb_pkg::A_STATUS, rd_q);
      check(32'(rd_q[5]), 32'h1);
      frame(2'h3, 32'h02000200);
    end
    rd(fwb_pkg::A_STATUS, rd_q);
    check(32'(rd_q[5:0]), 32'(fwb_pkg::OS_ITERS));
    report_and_stop();
  end
endmodule
`default_nettype wire
